// ---- arf_core_state.sv ----
// Purpose: Architectural state of an 8-bit core: registers, stack, RAM
// Assumes: Sequencer issues one command or data access per cycle
// Notes:   Stack commands take the RAM ahead of data accesses
//
// Notes on behaviour
// - Stack pointer 8 bits, pre-incremented on push/call
// - Stack pointer resets to 07h, first push 08h
// - Instruction address 16 bits, reset to 0000h
// - Two bank bits select one of four banks
// - Carry takes arithmetic carry and shift carry
// - Half carry from bit 3 carry
// - Range flag set on signed overflow
// - Clear instruction clears range flag; bit test and ALU update can set it
// - Bit test copies operand bit 6 to range flag
// - Parity flag follows accumulator, even count reads 1
// - Accumulator pairs with companion into 16 bits
// - Companion holds multiply/divide operand and result byte
// - External pointer 16 bits addresses external data
// - Special registers upper 128, direct address only
// - Separate 64K program and data spaces
// - Flash writable only while programming
// - Interrupt vectors 0003h onward, 8 bytes apart
// - Accepted interrupt loads its vector
// - Internal RAM 256 bytes holds stack
// - External data page FFh flagged as display data channel
`timescale 1ns/100ps
`include "arf_regs.svh"
module arf_core_state
    import arf_pkg::*;
#(
    parameter int RAM_DEPTH = 256
) (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire arf_cmd_e    cmd,
    input  wire logic [7:0]  cmd_data,
    input  wire logic [15:0] cmd_target,
    input  wire logic [1:0]  irq_num,
    output logic             busy,
    input  wire logic [7:0]  dir_addr,
    input  wire logic        dir_rd,
    input  wire logic        dir_wr,
    input  wire logic [7:0]  dir_wdata,
    input  wire logic [2:0]  reg_idx,
    input  wire logic        reg_rd,
    input  wire logic        reg_wr,
    output logic [7:0]       rdata,
    output logic             rdata_valid,
    input  wire logic        alu_upd,
    input  wire logic        alu_carry,
    input  wire logic        alu_half,
    input  wire logic        alu_range,
    input  wire logic        shift_upd,
    input  wire logic        shift_carry,
    input  wire logic        clear_range_flag_instr,
    input  wire logic        bit_test,
    input  wire logic [7:0]  bit_operand,
    input  wire logic        acc_ld,
    input  wire logic [7:0]  acc_in,
    input  wire logic        md_ld,
    input  wire logic [15:0] md_result,
    input  wire logic        xp_ld,
    input  wire logic [15:0] xp_in,
    input  wire logic        ext_wr,
    input  wire logic        flash_prog,
    output logic [15:0]      fetch_addr,
    output logic [15:0]      ext_addr,
    output logic [15:0]      acc_pair,
    output logic [7:0]       status_word,
    output logic             display_sel,
    output logic             flash_wr_en
);

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [7:0]  stack_pointer_reg;
    logic [15:0] instruction_address_reg;
    logic [15:0] target_reg;
    logic [7:0]  accumulator_reg;
    logic [7:0]  multiply_operand_register_reg;
    logic [7:0]  cpu_status_word_reg;
    logic [15:0] external_pointer_reg;
    arf_state_e  state_reg;
    logic        rd_ram_reg;
    logic        rd_any_reg;
    logic [7:0]  special_rdata_reg;
    logic        parity;
    logic [7:0]  status_view;
    logic        idle;
    logic        first_push;
    logic        second_push;
    logic        stk_adv;
    logic        pop_go;
    logic        dir_special;
    logic [7:0]  special_mux;

    arf_ram_if ram_bus ();

    arf_ram #(.DEPTH(RAM_DEPTH)) u_ram (
        .sys_clk (sys_clk),
        .port    (ram_bus.mem)
    );

    function automatic logic [15:0] vec_of(input logic [1:0] n);
        vec_of = `ARF_VEC_BASE + (`ARF_VEC_STEP * {14'h0000, n});
    endfunction : vec_of

    assign idle        = (state_reg == ST_IDLE);
    assign first_push  = idle && (cmd == CMD_PUSH || cmd == CMD_CALL || cmd == CMD_IRQ);
    assign second_push = (state_reg == ST_HIGH);
    assign stk_adv     = first_push || second_push;
    assign pop_go      = idle && (cmd == CMD_POP);
    assign busy        = second_push;
    assign dir_special = (dir_addr >= `ARF_SPECIAL_BASE);

    ////////////////////////////////////////////////////////////////////////
    // Call and interrupt sequencing
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (cmd == CMD_CALL || cmd == CMD_IRQ) begin
                        state_reg <= ST_HIGH;
                    end
                end
                ST_HIGH: state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            target_reg <= `ARF_IADDR_RST;
        end else if (idle && cmd == CMD_IRQ) begin
            target_reg <= vec_of(irq_num);
        end else if (idle && cmd == CMD_CALL) begin
            target_reg <= cmd_target;
        end
    end

    // Instruction address
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            instruction_address_reg <= `ARF_IADDR_RST;
        end else if (second_push) begin
            instruction_address_reg <= target_reg;
        end else if (idle && cmd == CMD_JUMP) begin
            instruction_address_reg <= cmd_target;
        end else if (idle && cmd == CMD_STEP) begin
            instruction_address_reg <= instruction_address_reg + 16'h0001;
        end
    end

    // Stack pointer: advanced before the byte lands
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            stack_pointer_reg <= `ARF_STACK_RST;
        end else if (stk_adv) begin
            stack_pointer_reg <= stack_pointer_reg + 8'h01;
        end else if (pop_go) begin
            stack_pointer_reg <= stack_pointer_reg - 8'h01;
        end else if (dir_wr && dir_addr == `ARF_ADDR_STACK) begin
            stack_pointer_reg <= dir_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RAM port: stack, then bank registers, then direct addresses
    always_comb begin
        ram_bus.addr  = 8'h00;
        ram_bus.we    = 1'b0;
        ram_bus.wdata = 8'h00;
        if (stk_adv) begin
            ram_bus.addr = stack_pointer_reg + 8'h01;
            ram_bus.we   = 1'b1;
            if (second_push) begin
                ram_bus.wdata = instruction_address_reg[15:8];
            end else if (cmd == CMD_PUSH) begin
                ram_bus.wdata = cmd_data;
            end else begin
                ram_bus.wdata = instruction_address_reg[7:0];
            end
        end else if (pop_go) begin
            ram_bus.addr = stack_pointer_reg;
        end else if (reg_rd || reg_wr) begin
            ram_bus.addr  = {`ARF_BANK_BITS, cpu_status_word_reg[`ARF_ST_BANK_HI],
                             cpu_status_word_reg[`ARF_ST_BANK_LO], reg_idx};
            ram_bus.we    = reg_wr;
            ram_bus.wdata = dir_wdata;
        end else if ((dir_rd || dir_wr) && !dir_special) begin
            ram_bus.addr  = dir_addr;
            ram_bus.we    = dir_wr;
            ram_bus.wdata = dir_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Accumulator and companion
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            accumulator_reg <= `ARF_ACC_RST;
        end else if (md_ld) begin
            accumulator_reg <= md_result[7:0];
        end else if (acc_ld) begin
            accumulator_reg <= acc_in;
        end else if (dir_wr && dir_addr == `ARF_ADDR_ACC) begin
            accumulator_reg <= dir_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            multiply_operand_register_reg <= `ARF_MOP_RST;
        end else if (md_ld) begin
            multiply_operand_register_reg <= md_result[15:8];
        end else if (dir_wr && dir_addr == `ARF_ADDR_MOP) begin
            multiply_operand_register_reg <= dir_wdata;
        end
    end

    assign acc_pair = {multiply_operand_register_reg, accumulator_reg};

    ////////////////////////////////////////////////////////////////////////
    // Status word; hardware events override a software write
    assign parity   = ~(^accumulator_reg);
    assign status_view = {cpu_status_word_reg[7:1], parity};
    assign status_word = status_view;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cpu_status_word_reg <= `ARF_STATUS_RST;
        end else begin
            if (dir_wr && dir_addr == `ARF_ADDR_STATUS) begin
                cpu_status_word_reg <= {dir_wdata[7:1], 1'b0};
            end
            if (clear_range_flag_instr) begin
                cpu_status_word_reg[`ARF_ST_RANGE] <= 1'b0;
            end
            if (bit_test) begin
                cpu_status_word_reg[`ARF_ST_RANGE] <= bit_operand[`ARF_BITTEST_BIT];
            end
            if (alu_upd) begin
                cpu_status_word_reg[`ARF_ST_CARRY] <= alu_carry;
                cpu_status_word_reg[`ARF_ST_HALF]  <= alu_half;
                cpu_status_word_reg[`ARF_ST_RANGE] <= alu_range;
            end
            if (shift_upd) begin
                cpu_status_word_reg[`ARF_ST_CARRY] <= shift_carry;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // External pointer and memory space steering
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            external_pointer_reg <= `ARF_XP_RST;
        end else if (xp_ld) begin
            external_pointer_reg <= xp_in;
        end else if (dir_wr && dir_addr == `ARF_ADDR_XPL) begin
            external_pointer_reg[7:0] <= dir_wdata;
        end else if (dir_wr && dir_addr == `ARF_ADDR_XPH) begin
            external_pointer_reg[15:8] <= dir_wdata;
        end
    end

    assign fetch_addr  = instruction_address_reg;
    assign ext_addr    = external_pointer_reg;
    assign display_sel = (external_pointer_reg[15:8] == `ARF_DISPLAY_PAGE);
    assign flash_wr_en = ext_wr && flash_prog;

    ////////////////////////////////////////////////////////////////////////
    // Read return, one cycle after the request
    always_comb begin
        case (dir_addr)
            `ARF_ADDR_STACK:  special_mux = stack_pointer_reg;
            `ARF_ADDR_XPL:    special_mux = external_pointer_reg[7:0];
            `ARF_ADDR_XPH:    special_mux = external_pointer_reg[15:8];
            `ARF_ADDR_STATUS: special_mux = status_view;
            `ARF_ADDR_ACC:    special_mux = accumulator_reg;
            `ARF_ADDR_MOP:    special_mux = multiply_operand_register_reg;
            default:          special_mux = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rd_ram_reg    <= 1'b0;
            rd_any_reg    <= 1'b0;
            special_rdata_reg <= 8'h00;
        end else begin
            rd_ram_reg    <= pop_go || (!stk_adv && (reg_rd || (dir_rd && !dir_special)));
            rd_any_reg    <= pop_go || (!stk_adv && (reg_rd || dir_rd));
            special_rdata_reg <= special_mux;
        end
    end

    assign rdata       = rd_ram_reg ? ram_bus.rdata : special_rdata_reg;
    assign rdata_valid = rd_any_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_stack_push_inc: assert property (idle && cmd == CMD_PUSH |=>
        stack_pointer_reg == $past(stack_pointer_reg) + 8'h01)
        else $error("stack pointer not advanced on push");
    a_stack_reset_val: assert property ($rose(nrst) |->
        stack_pointer_reg == 8'h07 && instruction_address_reg == 16'h0000)
        else $error("stack pointer or address wrong after reset");
    a_iaddr_step_inc: assert property (idle && cmd == CMD_STEP |=>
        instruction_address_reg == $past(instruction_address_reg) + 16'h0001)
        else $error("instruction address not stepped");
    a_bank_addr_sel: assert property (reg_wr && !stk_adv && !pop_go |->
        ram_bus.addr[4:3] == cpu_status_word_reg[4:3] && ram_bus.addr[7:5] == 3'h0)
        else $error("bank register address wrong");
    a_carry_alu_cap: assert property (alu_upd && !shift_upd |=>
        cpu_status_word_reg[7] == $past(alu_carry) && cpu_status_word_reg[6] == $past(alu_half))
        else $error("carry flags not captured");
    a_range_clear: assert property (clear_range_flag_instr && !bit_test && !alu_upd |=>
        cpu_status_word_reg[2] == 1'b0)
        else $error("range flag not cleared");
    a_range_bittest: assert property (bit_test && !alu_upd |=>
        cpu_status_word_reg[2] == $past(bit_operand[6]))
        else $error("bit test did not copy bit 6");
    a_parity_track: assert property (^{accumulator_reg, status_word[0]} == 1'b1)
        else $error("parity flag wrong");
    a_irq_vector: assert property (idle && cmd == CMD_IRQ ##1 busy |=>
        instruction_address_reg == 16'h0003 + {11'h000, $past(irq_num, 2), 3'h0})
        else $error("interrupt vector not loaded");
    a_call_two_push: assert property (idle && cmd == CMD_CALL |=>
        busy ##1 !busy && stack_pointer_reg == $past(stack_pointer_reg, 2) + 8'h02)
        else $error("call did not push two bytes");
    a_flash_guard: assert property (!flash_prog |-> !flash_wr_en)
        else $error("flash write outside programming");

    c_push_seen: cover property (idle && cmd == CMD_PUSH);
    c_irq_taken: cover property (idle && cmd == CMD_IRQ ##2 idle);
    c_bank_three: cover property (reg_wr && cpu_status_word_reg[4:3] == 2'b11);
    c_display_access: cover property (display_sel && ext_wr);

endmodule : arf_core_state

// ---- arf_regs.svh ----
// Purpose: Offsets, field positions, reset values of the core state block
// Assumes: Direct addresses of the special register area are 8 bits
// Notes:   Definitions only
`ifndef ARF_REGS_SVH
`define ARF_REGS_SVH

// Direct address map of the special register area
`define ARF_SPECIAL_BASE  8'h80
`define ARF_ADDR_STACK    8'h81
`define ARF_ADDR_XPL      8'h82
`define ARF_ADDR_XPH      8'h83
`define ARF_ADDR_STATUS   8'hD0
`define ARF_ADDR_ACC      8'hE0
`define ARF_ADDR_MOP      8'hF0

// Reset values
`define ARF_STACK_RST     8'h07
`define ARF_IADDR_RST     16'h0000
`define ARF_ACC_RST       8'h00
`define ARF_MOP_RST       8'h00
`define ARF_STATUS_RST    8'h00
`define ARF_XP_RST        16'h0000

// Status word fields
`define ARF_ST_CARRY      7
`define ARF_ST_HALF       6
`define ARF_ST_USER       5
`define ARF_ST_BANK_HI    4
`define ARF_ST_BANK_LO    3
`define ARF_ST_RANGE      2
`define ARF_ST_PARITY     0

// Interrupt vectors, bank and external data layout, bit test position
`define ARF_VEC_BASE      16'h0003
`define ARF_VEC_STEP      16'h0008
`define ARF_BANK_BITS     3'h0
`define ARF_DISPLAY_PAGE  8'hFF
`define ARF_BITTEST_BIT   6

`endif

// ---- arf_pkg.sv ----
// Purpose: Types shared by the core state block
// Assumes: Nothing
// Notes:   Commands issued by the sequencer each cycle
package arf_pkg;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_PUSH,
        CMD_POP,
        CMD_CALL,
        CMD_IRQ,
        CMD_JUMP,
        CMD_STEP
    } arf_cmd_e;

    typedef enum logic {
        ST_IDLE,
        ST_HIGH
    } arf_state_e;

    typedef logic [7:0] arf_byte_t;

endpackage : arf_pkg

// ---- arf_ram_if.sv ----
// Purpose: Port bundle between the state block and its internal RAM
// Assumes: Single port, registered read
// Notes:   None
`timescale 1ns/100ps
interface arf_ram_if;
    logic [7:0] addr;
    logic       we;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport ctl (output addr, output we, output wdata, input rdata);
    modport mem (input addr, input we, input wdata, output rdata);
endinterface : arf_ram_if

// ---- arf_ram.sv ----
// Purpose: Internal data RAM holding banks, bit area and stack
// Assumes: One access per cycle
// Notes:   Read data come from a register one cycle after the address
`timescale 1ns/100ps
module arf_ram #(
    parameter int DEPTH = 256
) (
    input  wire logic sys_clk,
    arf_ram_if.mem    port
);

    logic [7:0] mem_reg [DEPTH];
    logic [7:0] rdata_reg;

    always_ff @(posedge sys_clk) begin
        if (port.we) begin
            mem_reg[port.addr] <= port.wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        rdata_reg <= mem_reg[port.addr];
    end

    assign port.rdata = rdata_reg;

endmodule : arf_ram

// ---- arf_core_state_test.sv ----
// Purpose: Self-checking bench for the core state block
// Assumes: Registers reached by direct, bank and command accesses
// Notes:   Expected values are worked out from the register layout
`timescale 1ns/100ps
`include "arf_regs.svh"
module arf_core_state_test;
    import arf_pkg::*;

    logic        sys_clk, nrst, busy, rdata_valid, display_sel, flash_wr_en;
    logic        dir_rd, dir_wr, reg_rd, reg_wr, alu_upd, alu_carry, alu_half, alu_range;
    logic        shift_upd, shift_carry, clear_range_flag_instr, bit_test;
    logic        acc_ld, md_ld, xp_ld, ext_wr, flash_prog;
    arf_cmd_e    cmd;
    logic [1:0]  irq_num;
    logic [2:0]  reg_idx;
    logic [7:0]  cmd_data, dir_addr, dir_wdata, rdata, bit_operand, acc_in, status_word;
    logic [15:0] cmd_target, md_result, xp_in, fetch_addr, ext_addr, acc_pair;
    int          fail_count, check_count, cycles;

    arf_core_state u_arf_core_state (
        .sys_clk(sys_clk), .nrst(nrst), .cmd(cmd), .cmd_data(cmd_data),
        .cmd_target(cmd_target), .irq_num(irq_num), .busy(busy),
        .dir_addr(dir_addr), .dir_rd(dir_rd), .dir_wr(dir_wr), .dir_wdata(dir_wdata),
        .reg_idx(reg_idx), .reg_rd(reg_rd), .reg_wr(reg_wr), .rdata(rdata),
        .rdata_valid(rdata_valid), .alu_upd(alu_upd), .alu_carry(alu_carry),
        .alu_half(alu_half), .alu_range(alu_range), .shift_upd(shift_upd),
        .shift_carry(shift_carry),
        .clear_range_flag_instr(clear_range_flag_instr), .bit_test(bit_test),
        .bit_operand(bit_operand), .acc_ld(acc_ld), .acc_in(acc_in), .md_ld(md_ld),
        .md_result(md_result), .xp_ld(xp_ld), .xp_in(xp_in), .ext_wr(ext_wr),
        .flash_prog(flash_prog), .fetch_addr(fetch_addr), .ext_addr(ext_addr),
        .acc_pair(acc_pair), .status_word(status_word), .display_sel(display_sel),
        .flash_wr_en(flash_wr_en)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
        end
    endtask : chk16

    task automatic chkb(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
        end
    endtask : chkb

    task automatic tick;
        @(posedge sys_clk);
    endtask : tick

    // Takes the strobes set one edge earlier, then drops all but ext_wr and flash_prog
    task automatic step;
        @(posedge sys_clk);
        cmd <= CMD_NONE;
        {dir_rd, dir_wr, reg_rd, reg_wr, alu_upd, shift_upd} <= '0;
        {clear_range_flag_instr, bit_test, acc_ld, md_ld, xp_ld} <= '0;
        #1;
    endtask : step

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick();
        dir_addr <= a;
        dir_wdata <= d;
        dir_wr <= 1'b1;
        step();
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        tick();
        dir_addr <= a;
        dir_rd <= 1'b1;
        step();
        chkb(rdata_valid, 1'b1);
        chk8(rdata, exp);
    endtask : rd

    task automatic irq_or_call(input arf_cmd_e c, input logic [1:0] n);
        tick();
        cmd <= c;
        irq_num <= n;
        step();
        chkb(busy, 1'b1);
        tick();
        #1;
    endtask : irq_or_call

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] v;
        nrst = 1'b0;
        cmd = CMD_NONE;
        {dir_rd, dir_wr, reg_rd, reg_wr, alu_upd, alu_carry, alu_half, alu_range} = '0;
        {shift_upd, shift_carry, clear_range_flag_instr, bit_test} = '0;
        {acc_ld, md_ld, xp_ld, ext_wr, flash_prog, irq_num, reg_idx} = '0;
        {cmd_data, dir_addr, dir_wdata, bit_operand, acc_in} = '0;
        {cmd_target, md_result, xp_in} = '0;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        #1;
        chk16(fetch_addr, `ARF_IADDR_RST);
        chk16(ext_addr, `ARF_XP_RST);
        chk16(acc_pair, 16'h0000);
        chk8(status_word, 8'h01);
        rd(`ARF_ADDR_STACK, `ARF_STACK_RST);
        rd(8'hC5, 8'h00);
        tick();
        cmd <= CMD_PUSH;
        cmd_data <= 8'hA5;
        step();
        rd(`ARF_ADDR_STACK, 8'h08);
        rd(8'h08, 8'hA5);
        for (int b = 0; b < 4; b++) begin
            wr(`ARF_ADDR_STATUS, 8'(b << 3));
            chk8(status_word, 8'(b << 3) | 8'h01);
            tick();
            reg_idx <= 3'h5;
            dir_wdata <= 8'h60 + 8'(b);
            reg_wr <= 1'b1;
            step();
            rd(8'(b * 8 + 5), 8'h60 + 8'(b));
        end
        tick();
        reg_rd <= 1'b1;
        step();
        chk8(rdata, 8'h63);
        wr(`ARF_ADDR_STATUS, 8'h00);
        tick();
        {alu_upd, alu_carry, alu_half, alu_range} <= 4'hF;
        step();
        chk8(status_word, 8'hC5);
        tick();
        clear_range_flag_instr <= 1'b1;
        step();
        chk8(status_word, 8'hC1);
        tick();
        bit_test <= 1'b1;
        bit_operand <= 8'h40;
        step();
        chk8(status_word, 8'hC5);
        tick();
        bit_test <= 1'b1;
        bit_operand <= 8'hBF;
        step();
        chk8(status_word, 8'hC1);
        tick();
        shift_upd <= 1'b1;
        shift_carry <= 1'b0;
        step();
        chk8(status_word, 8'h41);
        tick();
        {alu_upd, alu_carry, alu_half, alu_range} <= 4'h8;
        step();
        chk8(status_word, 8'h01);
        for (int i = 0; i < 4; i++) begin
            v = 8'(32'h0703FF80 >> (24 - 8 * i));
            tick();
            acc_ld <= 1'b1;
            acc_in <= v;
            step();
            chkb(status_word[0], ~^v);
        end
        tick();
        md_ld <= 1'b1;
        md_result <= 16'h1234;
        step();
        chk16(acc_pair, 16'h1234);
        rd(`ARF_ADDR_MOP, 8'h12);
        rd(`ARF_ADDR_ACC, 8'h34);
        tick();
        xp_ld <= 1'b1;
        xp_in <= 16'hFF10;
        step();
        chk16(ext_addr, 16'hFF10);
        chkb(display_sel, 1'b1);
        rd(`ARF_ADDR_XPH, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            tick();
            {ext_wr, flash_prog} <= 2'(i);
            #1;
            chkb(flash_wr_en, i == 3);
        end
        wr(`ARF_ADDR_XPH, 8'hFE);
        chkb(display_sel, 1'b0);
        cmd_target <= 16'h1234;
        irq_or_call(CMD_CALL, 2'h0);
        chk16(fetch_addr, 16'h1234);
        rd(`ARF_ADDR_STACK, 8'h0A);
        for (int n = 0; n < 4; n++) begin
            irq_or_call(CMD_IRQ, 2'(n));
            chk16(fetch_addr, 16'h0003 + 16'(8 * n));
        end
        rd(8'h0B, 8'h34);
        rd(8'h0C, 8'h12);
        rd(8'h11, 8'h13);
        tick();
        cmd <= CMD_POP;
        step();
        chkb(rdata_valid, 1'b1);
        chk8(rdata, 8'h00);
        rd(`ARF_ADDR_STACK, 8'h11);
        tick();
        cmd <= CMD_JUMP;
        cmd_target <= 16'h00FF;
        step();
        chk16(fetch_addr, 16'h00FF);
        tick();
        cmd <= CMD_STEP;
        step();
        chk16(fetch_addr, 16'h0100);
        summarize();
    end

endmodule : arf_core_state_test
